/* hdl/tsil_irq.sv */
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE_01 - request register bit 0 is external pin flag, set on edge, reset 0
// RULE_02 - request register bit 4 is timer overflow flag, reset 0
// RULE_03 - software clears a flag by writing zero; flag stays set otherwise
// RULE_04 - stack register bit 7 is global enable, reset 0, gates service
// RULE_05 - accepting loads vector address 8 and deepens stack one level
// RULE_06 - one-level shadow buffer for accumulator and status, overwritten
// RULE_07 - save and restore skip the timeout and power-down status bits
// RULE_08 - configured pin edge sets external flag even when disabled
// RULE_09 - enabled external edge vectors when global enable is set
// RULE_10 - matching wake edge from power-down is latched and serviced first
// RULE_11 - edge field bits 4:3: 01 rise, 10 fall, 11 both, 00 reserved
// RULE_12 - every timer overflow sets timer flag regardless of enable
// RULE_13 - disabled timer source sets flag without vectoring
// RULE_14 - service software tests enable with flag to find source
// RULE_15 - entry clears global enable; return from interrupt sets it again
// RULE_16 - enable register bit 0 external, bit 4 timer, reset 0
// RULE_17 - pending test at each instruction boundary with enables
module tsil_irq
  import tsil_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_irq_line_i,
  input wire logic timer_overflow_i,
  input wire logic powerdown_i,
  input wire logic insn_boundary_i,
  input wire logic return_from_irq_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [7:0] accumulator_i,
  input wire logic [7:0] status_flags_i,
  output logic [7:0] accumulator_o,
  output logic [7:0] status_flags_o,
  output logic vector_take_o,
  output logic [10:0] vector_addr_o,
  output logic [1:0] stack_ptr_o,
  output logic irq_o
);
  logic ext_s1, ext_s2, ext_prev;
  logic [7:0] request_flag_reg;
  logic [7:0] irq_en;
  logic [7:0] edge_select_reg;
  logic global_irq_enable;
  logic [1:0] stack_ptr;
  logic [7:0] irq_mask;
  logic [7:0] shadow_acc, shadow_status;
  logic wake_latch;
  tsil_state_t state;
  logic wr, rd_go, edge_hit, take;
  logic [1:0] edge_sel;
  logic [7:0] wdat;

  // every check below samples on the core clock and idles in reset
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign rd_go = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wdat = wb_dat_i[7:0];
  assign edge_sel = edge_select_reg[BIT_EDGE_HI:BIT_EDGE_LO];

  // pin passes two flops before edge detection
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_prev <= 1'b0;
    end else if (clk_en_i) begin
      ext_s1 <= ext_irq_line_i;
      ext_s2 <= ext_s1;
      ext_prev <= ext_s2;
    end
  end

  always_comb begin
    case (edge_sel) // RULE_11
      EDGE_RISE: edge_hit = ext_s2 && !ext_prev;
      EDGE_FALL: edge_hit = !ext_s2 && ext_prev;
      EDGE_BOTH: edge_hit = ext_s2 ^ ext_prev;
      default: edge_hit = 1'b0;
    endcase
  end

  // set wins over a clearing write in the same cycle
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      request_flag_reg <= 8'h0000; // RULE_01 RULE_02
    end else if (clk_en_i) begin
      if (wr && is_addr(wb_adr_i, ADDR_REQ_FLAG)) begin
        request_flag_reg <= wdat & REQ_MASK; // RULE_03
      end
      if (edge_hit) begin
        request_flag_reg[BIT_EXT] <= 1'b1; // RULE_08 RULE_01
      end
      if (timer_overflow_i) begin
        request_flag_reg[BIT_TMR] <= 1'b1; // RULE_12 RULE_02
      end
    end
  end

  // a matching edge seen while powered down keeps service ahead of code
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wake_latch <= 1'b0;
    end else if (clk_en_i) begin
      if (powerdown_i && edge_hit) begin
        wake_latch <= 1'b1; // RULE_10
      end else if (take) begin
        wake_latch <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_en <= 8'h0000; // RULE_16
      edge_select_reg <= 8'h0000; // RULE_11
      irq_mask <= 8'h0000;
    end else if (clk_en_i && wr) begin
      if (is_addr(wb_adr_i, ADDR_IRQ_EN)) begin
        irq_en <= wdat & REQ_MASK; // RULE_16
      end
      if (is_addr(wb_adr_i, ADDR_EDGE_SEL)) begin
        edge_select_reg <= wdat & STATUS_KEEP_MASK;
      end
      if (is_addr(wb_adr_i, ADDR_IRQ_MASK)) begin
        irq_mask <= wdat & REQ_MASK;
      end
    end
  end

  // acceptance at an instruction boundary, not in power-down
  assign take = clk_en_i && insn_boundary_i && !powerdown_i
    && global_irq_enable
    && ((|(request_flag_reg & irq_en)) || wake_latch); // RULE_17 RULE_09 RULE_13 RULE_04

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      global_irq_enable <= 1'b0; // RULE_04
      stack_ptr <= STACK_PTR_RESET;
      state <= TSIL_RUN;
    end else if (clk_en_i) begin
      if (take) begin
        global_irq_enable <= 1'b0; // RULE_15
        stack_ptr <= stack_ptr - 2'h1; // RULE_05
        state <= TSIL_SERVICE;
      end else if (return_from_irq_i) begin
        global_irq_enable <= 1'b1; // RULE_15
        stack_ptr <= stack_ptr + 2'h1;
        state <= TSIL_RUN;
      end else if (wr && is_addr(wb_adr_i, ADDR_STACK_PTR)) begin
        global_irq_enable <= wdat[BIT_GIE];
        stack_ptr <= wdat[1:0];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vector_take_o <= 1'b0;
      vector_addr_o <= 11'h0000;
    end else if (clk_en_i) begin
      vector_take_o <= take;
      if (take) begin
        vector_addr_o <= VECTOR_ADDR; // RULE_05
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shadow_acc <= 8'h0000;
      shadow_status <= 8'h0000;
    end else if (clk_en_i && push_i) begin
      shadow_acc <= accumulator_i; // RULE_06
      shadow_status <= status_flags_i & ~STATUS_KEEP_MASK; // RULE_07
    end
  end

  // restore keeps the live timeout and power-down bits
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      accumulator_o <= 8'h0000;
      status_flags_o <= 8'h0000;
    end else if (clk_en_i) begin
      if (pop_i) begin
        accumulator_o <= shadow_acc; // RULE_06
        status_flags_o <= shadow_status
          | (status_flags_i & STATUS_KEEP_MASK); // RULE_07
      end else begin
        accumulator_o <= accumulator_i;
        status_flags_o <= status_flags_i;
      end
    end
  end

  assign stack_ptr_o = stack_ptr;
  assign irq_o = |(request_flag_reg & irq_mask);

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en_i) begin
      wb_ack_o <= rd_go;
      if (rd_go) begin
        case (wb_adr_i)
          ADDR_EDGE_SEL: wb_dat_o <= {24'h00_0000, edge_select_reg};
          ADDR_REQ_FLAG: wb_dat_o <= {24'h00_0000, request_flag_reg};
          ADDR_IRQ_EN: wb_dat_o <= {24'h00_0000, irq_en};
          ADDR_STACK_PTR: wb_dat_o <= {24'h00_0000, global_irq_enable,
                                       5'h00, stack_ptr};
          ADDR_SHADOW: wb_dat_o <= {16'h0000, shadow_status, shadow_acc};
          ADDR_IRQ_MASK: wb_dat_o <= {24'h00_0000, irq_mask};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  a_timer_set: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    clk_en_i && timer_overflow_i |=> request_flag_reg[BIT_TMR]) // RULE_12
    else $error("timer flag not set");
  a_ext_set: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    clk_en_i && edge_hit |=> request_flag_reg[BIT_EXT]) // RULE_08
    else $error("ext flag not set");
  a_flag_holds: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    request_flag_reg[BIT_TMR] && !(wr && is_addr(wb_adr_i, ADDR_REQ_FLAG))
    |=> request_flag_reg[BIT_TMR]) // RULE_03
    else $error("flag dropped");
  a_no_take_gie: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !global_irq_enable |=> !vector_take_o) // RULE_04
    else $error("vector without gie");
  a_vector_addr: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    vector_take_o |-> vector_addr_o == VECTOR_ADDR
    && !global_irq_enable) // RULE_05
    else $error("bad vector");
  a_stack_deep: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    take |=> stack_ptr == $past(stack_ptr) - 2'h1) // RULE_05
    else $error("stack not deepened");
  a_return_from_irq_gie: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    clk_en_i && return_from_irq_i && !take |=> global_irq_enable) // RULE_15
    else $error("gie not restored");
  a_tmr_masked: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !irq_en[BIT_TMR] && !request_flag_reg[BIT_EXT] && !wake_latch
    |-> !take) // RULE_13
    else $error("vector with timer disabled");
  a_pop_keep: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    clk_en_i && pop_i |=> (status_flags_o & STATUS_KEEP_MASK)
    == ($past(status_flags_i) & STATUS_KEEP_MASK)) // RULE_07
    else $error("status bits restored");

  // service entry and vectoring
  a_gie_clear: assert property (take |=> !global_irq_enable) // RULE_15
    else $error("gie not cleared on entry");
  a_vec_hold: assert property (!take |=> $stable(vector_addr_o)) // RULE_05
    else $error("vector address moved");
  a_ext_vector: assert property (clk_en_i && insn_boundary_i // RULE_09
    && !powerdown_i && global_irq_enable && request_flag_reg[BIT_EXT]
    && irq_en[BIT_EXT] |=> vector_take_o)
    else $error("enabled pin request not taken");
  a_timer_vector: assert property (clk_en_i && insn_boundary_i // RULE_17
    && !powerdown_i && global_irq_enable && request_flag_reg[BIT_TMR]
    && irq_en[BIT_TMR] |=> vector_take_o)
    else $error("enabled timer request not taken");

  // edge decode and wake latch
  a_edge_none: assert property (!(|edge_sel) |-> !edge_hit) // RULE_11
    else $error("edge seen in reserved mode");
  a_pd_block: assert property (powerdown_i |-> !take) // RULE_10
    else $error("vector taken in power-down");
  a_wake_keep: assert property (clk_en_i && wake_latch && !take // RULE_10
    |=> wake_latch)
    else $error("wake latch lost before service");

  // shadow buffer, one level only; bus ack pulse
  a_push_save: assert property (clk_en_i && push_i // RULE_06
    |=> shadow_acc == $past(accumulator_i))
    else $error("accumulator not saved");
  a_push_skip: assert property (clk_en_i && push_i // RULE_07
    |=> (shadow_status & STATUS_KEEP_MASK) == 8'h00)
    else $error("excluded status bits saved");
  a_pop_acc: assert property (clk_en_i && pop_i // RULE_06
    |=> accumulator_o == $past(shadow_acc))
    else $error("accumulator not restored");
  a_ack_pulse: assert property (clk_en_i && wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  c_both: cover property (edge_sel == EDGE_BOTH && edge_hit);
  c_take: cover property (@(posedge core_clk_i) vector_take_o);
  c_wake: cover property (@(posedge core_clk_i) wake_latch ##[1:20] take);
  c_return_from_irq: cover property (@(posedge core_clk_i) take ##[1:50]
    return_from_irq_i);
endmodule
`default_nettype wire

/* hdl/tsil_pkg.sv */
package tsil_pkg;
  localparam logic [7:0] ADDR_EDGE_SEL = 8'h00_bf;
  localparam logic [7:0] ADDR_REQ_FLAG = 8'h00_c8;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h00_c9;
  localparam logic [7:0] ADDR_STACK_PTR = 8'h00_df;
  localparam logic [7:0] ADDR_SHADOW = 8'h00_e8;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h00_e9;
  localparam int BIT_EXT = 0;
  localparam int BIT_TMR = 4;
  localparam int BIT_GIE = 7;
  localparam int BIT_EDGE_LO = 3;
  localparam int BIT_EDGE_HI = 4;
  localparam int BIT_TIMEOUT = 4;
  localparam int BIT_PWRDN = 3;
  localparam logic [7:0] REQ_MASK = 8'h0011;
  localparam logic [7:0] STATUS_KEEP_MASK = 8'h0018;
  localparam logic [1:0] STACK_PTR_RESET = 2'h3;
  localparam logic [10:0] VECTOR_ADDR = 11'h0008;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  typedef enum logic [1:0] {
    TSIL_RUN = 2'b00,
    TSIL_SERVICE = 2'b01
  } tsil_state_t;
endpackage

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
  import tsil_pkg::*;
;
  logic clk = 0, resetn = 0, cyc = 0, stb = 0, we = 0, ack, pin = 0;
  logic tov = 0, pd = 0, rq_ret = 0, rq_push = 0, rq_pop = 0;
  logic bnd, ret, psh, pop, take, irq;
  logic [7:0] adr = 0, acc_in = 0, st_in = 0, acc_c, st_c, acc_o, st_o;
  logic [7:0] a2, s2, a3;
  logic [31:0] wdat = 0, rdat;
  logic [10:0] vaddr;
  logic [1:0] sp;
  int n_errors = 0, n_compared = 0, seed = 88;
  int n_take = 0, w = 0;
  always #50 clk = ~clk;
  // count vector pulses so one that lands inside a bus call is not missed
  always @(posedge clk) if (take === 1'b1) n_take <= n_take + 1;
  tsil_core_model core (.clk_i(clk), .resetn_i(resetn), .ret_req_i(rq_ret),
    .push_req_i(rq_push), .pop_req_i(rq_pop), .acc_i(acc_in),
    .status_i(st_in), .boundary_o(bnd), .ret_o(ret), .push_o(psh),
    .pop_o(pop), .acc_o(acc_c), .status_o(st_c));
  tsil_irq uut (.core_clk_i(clk), .resetn_i(resetn), .clk_en_i(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext_irq_line_i(pin), .timer_overflow_i(tov), .powerdown_i(pd),
    .insn_boundary_i(bnd), .return_from_irq_i(ret), .push_i(psh),
    .pop_i(pop), .accumulator_i(acc_c), .status_flags_i(st_c),
    .accumulator_o(acc_o), .status_flags_o(st_o), .vector_take_o(take),
    .vector_addr_o(vaddr), .stack_ptr_o(sp), .irq_o(irq));
  task automatic complete_run();
    if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(logic w, logic [7:0] a, d, output logic [7:0] q);
    int i;
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= {24'h00_0000, d};
    i = 0;
    do begin @(posedge clk); i++; end while (ack !== 1'b1 && i < 20);
    q = rdat[7:0];
    cyc <= 0; stb <= 0;
    @(posedge clk);
    if (i >= 20) begin n_errors++; complete_run(); end
  endtask
  task automatic wr(logic [7:0] a, d);
    logic [7:0] q;
    bus(1, a, d, q);
  endtask
  task automatic rd(logic [7:0] a, e);
    logic [7:0] q;
    bus(0, a, 8'h00, q);
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, q});
  endtask
  task automatic pulse_ret();
    rq_ret <= 1; tick(1); rq_ret <= 0; tick(3);
  endtask
  task automatic wait_take(int want);
    int i;
    i = 0;
    do begin @(posedge clk); i++; end while (n_take < want && i < 40);
    if (i >= 40) begin n_errors++; complete_run(); end
    chk("vector", {5'h00, VECTOR_ADDR}, {5'h00, vaddr});
    chk("stack", 16'h0002, {14'h0000, sp});
  endtask
  // status bits 4 and 3 never come from the shadow copy
  function automatic logic [7:0] pop_status(logic [7:0] saved, live);
    return (saved & ~STATUS_KEEP_MASK) | (live & STATUS_KEEP_MASK);
  endfunction
  initial begin
    tick(4);
    resetn <= 1;
    rd(ADDR_EDGE_SEL, 8'h00);
    rd(ADDR_REQ_FLAG, 8'h00);
    rd(ADDR_IRQ_EN, 8'h00);
    rd(ADDR_STACK_PTR, 8'h03);
    rd(8'h10, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_EDGE_SEL, 8'(m << 3));
      wr(ADDR_REQ_FLAG, 8'h00);
      pin <= 1; tick(6);
      rd(ADDR_REQ_FLAG, {7'h00, m[0]});
      wr(ADDR_REQ_FLAG, 8'h00);
      pin <= 0; tick(6);
      rd(ADDR_REQ_FLAG, {7'h00, m[1]});
    end
    wr(ADDR_REQ_FLAG, 8'h00);
    wr(ADDR_EDGE_SEL, 8'h08);
    wr(ADDR_STACK_PTR, 8'h83);
    tov <= 1; tick(1); tov <= 0; tick(6);
    rd(ADDR_REQ_FLAG, 8'h10);
    chk("stack", 16'h0003, {14'h0000, sp});
    chk("irq", 16'h0000, {15'h0000, irq});
    wr(ADDR_IRQ_MASK, 8'h11);
    chk("irq", 16'h0001, {15'h0000, irq});
    wr(ADDR_IRQ_EN, 8'h10);
    wait_take(1);
    tick(2);
    rd(ADDR_STACK_PTR, 8'h02);
    rd(ADDR_IRQ_EN, 8'h10);
    rd(ADDR_REQ_FLAG, 8'h10);
    wr(ADDR_REQ_FLAG, 8'h00);
    pulse_ret();
    rd(ADDR_STACK_PTR, 8'h83);
    wr(ADDR_IRQ_EN, 8'h01);
    pd <= 1; pin <= 1; tick(10);
    chk("stack", 16'h0003, {14'h0000, sp});
    pd <= 0;
    wait_take(2);
    rd(ADDR_REQ_FLAG, 8'h01);
    wr(ADDR_REQ_FLAG, 8'h00);
    pulse_ret();
    for (int k = 0; k < 2; k++) begin
      a2 = 8'($random(seed)); s2 = 8'($random(seed));
      acc_in <= a2; st_in <= s2; tick(1);
      rq_push <= 1; tick(1); rq_push <= 0; tick(2);
    end
    a3 = 8'($random(seed)); acc_in <= a3; st_in <= ~s2; tick(2);
    rq_pop <= 1; tick(1); rq_pop <= 0;
    w = 0;
    do begin @(posedge clk); w++; end while (pop !== 1'b1 && w < 20);
    if (w >= 20) n_errors++;
    @(posedge clk);
    chk("acc", {8'h00, a2}, {8'h00, acc_o});
    chk("status", {8'h00, pop_status(s2, ~s2)}, {8'h00, st_o});
    complete_run();
  end
endmodule
`default_nettype wire

/* tb/tsil_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tsil_core_model (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ret_req_i,
  input wire logic push_req_i,
  input wire logic pop_req_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] status_i,
  output logic boundary_o,
  output logic ret_o,
  output logic push_o,
  output logic pop_o,
  output logic [7:0] acc_o,
  output logic [7:0] status_o
);
  logic [1:0] step;
  // boundaries come every fourth cycle, so acceptance is not always prompt
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      step <= 2'h0;
      boundary_o <= 1'b0;
    end else begin
      step <= step + 2'h1;
      boundary_o <= (step == 2'h0);
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ret_o <= 1'b0;
      push_o <= 1'b0;
      pop_o <= 1'b0;
      acc_o <= 8'h00;
      status_o <= 8'h00;
    end else begin
      ret_o <= ret_req_i;
      push_o <= push_req_i;
      pop_o <= pop_req_i;
      acc_o <= acc_i;
      status_o <= status_i;
    end
  end
endmodule
`default_nettype wire
